// ==== rtl/fp_state_defs.svh ====
// field positions, codes and reset values of the floating-point state
`ifndef FP_STATE_DEFS_SVH
`define FP_STATE_DEFS_SVH
`define FP_REG_WIDTH       32
`define FP_REG_COUNT       32
`define FP_ADDR_W          5
`define CSR_WIDTH          32
`define CSR_RSVD_W         24
`define RM_W               3
`define FLAGS_W            5
`define RM_MSB             7
`define RM_LSB             5
`define FLAGS_MSB          4
`define FLAGS_LSB          0
`define FLAG_INVALID       4
`define FLAG_DIV_ZERO      3
`define FLAG_OVERFLOW      2
`define FLAG_UNDERFLOW     1
`define FLAG_INEXACT       0
`define RM_NEAREST_EVEN    3'h0
`define RM_TOWARD_ZERO     3'h1
`define RM_TOWARD_NEG_INF  3'h2
`define RM_TOWARD_POS_INF  3'h3
`define RM_NEAREST_MAX_MAG 3'h4
`define RM_RESERVED_A      3'h5
`define RM_RESERVED_B      3'h6
`define RM_USE_DYNAMIC     3'h7
`define RM_RESET           3'h0
`define FLAGS_RESET        5'h00
`define FP_REG_RESET       32'h0000_0000
`define CSR_RSVD_ZERO      24'h00_0000
`endif

// ==== rtl/fp_state_pkg.sv ====
// types shared by the floating-point state block
package fp_state_pkg;
  // control/status access commands from the core
  typedef enum logic [2:0] {
    read_whole_status,
    swap_whole_status,
    read_round_field,
    swap_round_field,
    read_flag_field,
    swap_flag_field
  } csr_op_t;
endpackage : fp_state_pkg

// ==== rtl/fp_state_regfile.sv ====
// floating-point register file and control/status word
`timescale 1ns/1ps
`include "fp_state_defs.svh"

// Function
// - thirty-two 32-bit floating-point registers, separate from integer ones.
// - one 32-bit read/write control/status word with rounding mode and flags.
// - rounding field at bits 7..5; field read returns it zero-extended.
// - rounding swap returns old field, loads low three source bits.
// - flags at bits 4..0, invalid down to inexact; own read and swap.
// - whole read copies the word unchanged to the destination.
// - whole swap returns old word, then writes the source value.
// - upper bits 31..8 ignore writes and read as zero.
// - instruction code 111 picks the dynamic field, else static code.
// - codes 000..100 decode to the five defined rounding directions.
// - static 101,110 and dynamic 101..111 are reserved.
// - rounding field decoded for legality even when rounding is irrelevant.
// - reserved rounding encoding may raise illegal-instruction.
// - flags are sticky until software clears the field.
// - setting a flag never traps; software tests flags.
module fp_state_regfile
  import fp_state_pkg::*;
#(
  parameter int FP_REG_WIDTH = `FP_REG_WIDTH,
  parameter int FP_REG_COUNT = `FP_REG_COUNT
) (
  input  wire logic                      ref_clk,         // core clock
  input  wire logic                      rst,             // sync reset
  // floating-point register ports
  input  wire logic                      fp_wr_en,        // write strobe
  input  wire logic [`FP_ADDR_W-1:0]     fp_wr_addr,      // write index
  input  wire logic [FP_REG_WIDTH-1:0]   fp_wr_data,      // write value
  input  wire logic                      fp_rd_en,        // read strobe
  input  wire logic [`FP_ADDR_W-1:0]     fp_rd_addr_a,    // operand a index
  input  wire logic [`FP_ADDR_W-1:0]     fp_rd_addr_b,    // operand b index
  input  wire logic [`FP_ADDR_W-1:0]     fp_rd_addr_c,    // operand c index
  output logic [FP_REG_WIDTH-1:0]        fp_rd_data_a_ff, // operand a
  output logic [FP_REG_WIDTH-1:0]        fp_rd_data_b_ff, // operand b
  output logic [FP_REG_WIDTH-1:0]        fp_rd_data_c_ff, // operand c
  output logic                           fp_rd_valid_ff,  // operands ready
  // control/status access
  input  wire logic                      csr_req,         // access strobe
  input  wire fp_state_pkg::csr_op_t     csr_op,          // access kind
  input  wire logic [`CSR_WIDTH-1:0]     src_int_reg,     // source value
  output logic [`CSR_WIDTH-1:0]          csr_rdata_ff,    // old value
  output logic                           csr_rvalid_ff,   // answer strobe
  // exception indications from the execution unit
  input  wire logic                      exc_valid,       // op completes
  input  wire logic [`FLAGS_W-1:0]       exc_flags,       // raised flags
  // rounding-mode resolution
  input  wire logic                      rm_req,          // decode strobe
  input  wire logic [`RM_W-1:0]          insn_round_select, // insn field
  output logic [`RM_W-1:0]               eff_round_mode_ff, // mode to use
  output logic                           round_reserved_ff, // reserved enc
  output logic                           illegal_insn_ff, // raise illegal
  output logic                           rm_valid_ff,     // result strobe
  // current state
  output logic [`RM_W-1:0]               round_field_ff,  // dynamic mode
  output logic [`FLAGS_W-1:0]            flags_ff         // accrued flags
);
  import fp_state_pkg::*;

  // storage, indexed by register number
  logic [FP_REG_WIDTH-1:0] fp_regs [FP_REG_COUNT];
  logic [`RM_W-1:0]        nxt_round_field;
  logic [`FLAGS_W-1:0]     nxt_flags;
  logic [`CSR_WIDTH-1:0]   nxt_csr_rdata;
  logic                    sw_round_wr;
  logic                    sw_flags_wr;
  logic [`RM_W-1:0]        nxt_eff_mode;
  logic                    nxt_reserved;

  // whole word view; upper bits are never stored
  function automatic logic [`CSR_WIDTH-1:0] pack_word(
    input logic [`RM_W-1:0]    rm,
    input logic [`FLAGS_W-1:0] fl
  );
    pack_word = {`CSR_RSVD_ZERO, rm, fl};
  endfunction : pack_word

  // reserved codes: 101 and 110 always, 111 only when held in the field
  function automatic logic code_reserved(
    input logic [`RM_W-1:0] code,
    input logic             from_field
  );
    code_reserved = (code == `RM_RESERVED_A) || (code == `RM_RESERVED_B)
                  || (from_field && (code == `RM_USE_DYNAMIC));
  endfunction : code_reserved

  // register file writes; separate from integer state
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < FP_REG_COUNT; i++) begin
        fp_regs[i] <= `FP_REG_RESET;
      end
    end else if (fp_wr_en) begin
      fp_regs[fp_wr_addr] <= fp_wr_data;
    end
  end

  // registered reads; a same-cycle write is seen one access later
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fp_rd_data_a_ff <= `FP_REG_RESET;
      fp_rd_data_b_ff <= `FP_REG_RESET;
      fp_rd_data_c_ff <= `FP_REG_RESET;
      fp_rd_valid_ff  <= 1'b0;
    end else begin
      fp_rd_valid_ff <= fp_rd_en;
      if (fp_rd_en) begin
        fp_rd_data_a_ff <= fp_regs[fp_rd_addr_a];
        fp_rd_data_b_ff <= fp_regs[fp_rd_addr_b];
        fp_rd_data_c_ff <= fp_regs[fp_rd_addr_c];
      end
    end
  end

  // which fields a software access writes
  assign sw_round_wr = csr_req && ((csr_op == swap_whole_status)
                     || (csr_op == swap_round_field));
  assign sw_flags_wr = csr_req && ((csr_op == swap_whole_status)
                     || (csr_op == swap_flag_field));

  // next field values; a same-cycle exception still lands after a write
  always_comb begin
    nxt_round_field = round_field_ff;
    nxt_flags       = flags_ff;
    if (sw_round_wr) begin
      if (csr_op == swap_whole_status) begin
        nxt_round_field = src_int_reg[`RM_MSB:`RM_LSB];
      end else begin
        nxt_round_field = src_int_reg[`RM_W-1:0];
      end
    end
    if (sw_flags_wr) begin
      nxt_flags = src_int_reg[`FLAGS_MSB:`FLAGS_LSB];
    end
    if (exc_valid) begin
      nxt_flags = nxt_flags | exc_flags;
    end
  end

  // control/status state; no trap output exists for flags
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      round_field_ff <= `RM_RESET;
      flags_ff       <= `FLAGS_RESET;
    end else begin
      round_field_ff <= nxt_round_field;
      flags_ff       <= nxt_flags;
    end
  end

  // answer always carries the value before this access
  always_comb begin
    nxt_csr_rdata = pack_word(`RM_RESET, `FLAGS_RESET);
    case (csr_op)
      read_whole_status,
      swap_whole_status: begin
        nxt_csr_rdata = pack_word(round_field_ff, flags_ff);
      end
      read_round_field,
      swap_round_field: begin
        nxt_csr_rdata = {{(`CSR_WIDTH-`RM_W){1'b0}}, round_field_ff};
      end
      read_flag_field,
      swap_flag_field: begin
        nxt_csr_rdata = {{(`CSR_WIDTH-`FLAGS_W){1'b0}}, flags_ff};
      end
      default: begin
        nxt_csr_rdata = pack_word(`RM_RESET, `FLAGS_RESET);
      end
    endcase
  end

  // access answer one cycle after the request
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      csr_rdata_ff  <= pack_word(`RM_RESET, `FLAGS_RESET);
      csr_rvalid_ff <= 1'b0;
    end else begin
      csr_rvalid_ff <= csr_req;
      if (csr_req) begin
        csr_rdata_ff <= nxt_csr_rdata;
      end
    end
  end

  // static or dynamic selection; legality checked for every instruction
  always_comb begin
    if (insn_round_select == `RM_USE_DYNAMIC) begin
      nxt_eff_mode = round_field_ff;
      nxt_reserved = code_reserved(round_field_ff, 1'b1);
    end else begin
      nxt_eff_mode = insn_round_select;
      nxt_reserved = code_reserved(insn_round_select, 1'b0);
    end
  end

  // resolution result; reserved encodings are reported as illegal
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      eff_round_mode_ff <= `RM_NEAREST_EVEN;
      round_reserved_ff <= 1'b0;
      illegal_insn_ff   <= 1'b0;
      rm_valid_ff       <= 1'b0;
    end else begin
      rm_valid_ff       <= rm_req;
      illegal_insn_ff   <= rm_req && nxt_reserved;
      if (rm_req) begin
        eff_round_mode_ff <= nxt_eff_mode;
        round_reserved_ff <= nxt_reserved;
      end
    end
  end

  // checks next to the logic
  reset_clear_a: assert property (@(posedge ref_clk)
    rst |=> (round_field_ff == `RM_RESET) && (flags_ff == `FLAGS_RESET))
    else $error("fields not cleared by reset");

  flag_sticky_a: assert property (@(posedge ref_clk) disable iff (rst)
    !sw_flags_wr |=> ((flags_ff & $past(flags_ff)) == $past(flags_ff)))
    else $error("flag dropped without software write");

  flag_merge_a: assert property (@(posedge ref_clk) disable iff (rst)
    exc_valid |=> ((flags_ff & $past(exc_flags)) == $past(exc_flags)))
    else $error("raised exception not accrued");

  whole_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    (csr_req && (csr_op == read_whole_status)) |=>
      csr_rvalid_ff && (csr_rdata_ff[`RM_MSB:`RM_LSB] == $past(round_field_ff))
      && (csr_rdata_ff[`FLAGS_MSB:`FLAGS_LSB] == $past(flags_ff))
      && $stable(round_field_ff))
    else $error("whole read wrong or altered state");

  upper_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
    csr_rvalid_ff |-> (csr_rdata_ff[`CSR_WIDTH-1:`RM_MSB+1] == `CSR_RSVD_ZERO))
    else $error("reserved bits read nonzero");

  round_swap_a: assert property (@(posedge ref_clk) disable iff (rst)
    (csr_req && (csr_op == swap_round_field)) |=>
      (round_field_ff == $past(src_int_reg[`RM_W-1:0]))
      && (csr_rdata_ff == {{(`CSR_WIDTH-`RM_W){1'b0}}, $past(round_field_ff)}))
    else $error("rounding swap wrong");

  whole_swap_a: assert property (@(posedge ref_clk) disable iff (rst)
    (csr_req && (csr_op == swap_whole_status) && !exc_valid) |=>
      (pack_word(round_field_ff, flags_ff) ==
       {`CSR_RSVD_ZERO, $past(src_int_reg[`RM_MSB:`FLAGS_LSB])}))
    else $error("whole swap did not load source");

  dyn_select_a: assert property (@(posedge ref_clk) disable iff (rst)
    (rm_req && (insn_round_select == `RM_USE_DYNAMIC)) |=>
      rm_valid_ff && (eff_round_mode_ff == $past(round_field_ff)))
    else $error("dynamic mode not taken from field");

  static_rsvd_a: assert property (@(posedge ref_clk) disable iff (rst)
    (rm_req && ((insn_round_select == `RM_RESERVED_A)
      || (insn_round_select == `RM_RESERVED_B))) |=>
      round_reserved_ff && illegal_insn_ff)
    else $error("static reserved code not flagged");

  legal_code_a: assert property (@(posedge ref_clk) disable iff (rst)
    (rm_req && (insn_round_select <= `RM_NEAREST_MAX_MAG)) |=>
      !round_reserved_ff && (eff_round_mode_ff == $past(insn_round_select)))
    else $error("legal static code mishandled");

  // field accesses, same-cycle merges and dynamic legality
  round_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    (csr_req && (csr_op == read_round_field)) |=>
      (csr_rdata_ff == {{(`CSR_WIDTH-`RM_W){1'b0}}, $past(round_field_ff)})
      && $stable(round_field_ff))
    else $error("rounding field read wrong");

  flag_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    (csr_req && (csr_op == read_flag_field) && !exc_valid) |=>
      (csr_rdata_ff == {{(`CSR_WIDTH-`FLAGS_W){1'b0}}, $past(flags_ff)})
      && $stable(flags_ff))
    else $error("flag field read wrong");

  flag_swap_a: assert property (@(posedge ref_clk) disable iff (rst)
    (csr_req && (csr_op == swap_flag_field) && !exc_valid) |=>
      (flags_ff == $past(src_int_reg[`FLAGS_MSB:`FLAGS_LSB]))
      && (csr_rdata_ff == {{(`CSR_WIDTH-`FLAGS_W){1'b0}}, $past(flags_ff)}))
    else $error("flag field swap wrong");

  swap_merge_a: assert property (@(posedge ref_clk) disable iff (rst)
    (sw_flags_wr && exc_valid && (csr_op == swap_flag_field)) |=>
      (flags_ff == ($past(src_int_reg[`FLAGS_MSB:`FLAGS_LSB])
                    | $past(exc_flags))))
    else $error("same-cycle write and exception not merged");

  dyn_rsvd_a: assert property (@(posedge ref_clk) disable iff (rst)
    (rm_req && (insn_round_select == `RM_USE_DYNAMIC)
      && (round_field_ff > `RM_NEAREST_MAX_MAG)) |=>
      round_reserved_ff && illegal_insn_ff)
    else $error("dynamic reserved field not flagged");

endmodule : fp_state_regfile

// ==== verif/fp_exec_model.sv ====
// execution-unit stand-in that reports completions with flags
`timescale 1ns/1ps
module fp_exec_model (
  input  wire logic       ref_clk,   // core clock
  input  wire logic       rst,       // sync reset
  input  wire logic       fire,      // bench asks for a completion
  input  wire logic [4:0] raise,     // flags to report with it
  output logic            exc_valid, // completion strobe
  output logic [4:0]      exc_flags  // flags, junk when not valid
);
  logic       pend_ff;
  logic [4:0] pend_flags_ff;
  // capture the request first so the bench can drop it at once
  always_ff @(posedge ref_clk) begin
    pend_ff       <= fire & ~rst;
    pend_flags_ff <= raise;
  end
  // flags mean nothing without the strobe, so scramble them then
  always @(negedge ref_clk) begin
    exc_valid <= pend_ff;
    exc_flags <= pend_ff ? pend_flags_ff : ~exc_flags;
  end
  initial begin
    exc_valid = 1'b0;
    exc_flags = 5'h00;
  end
endmodule : fp_exec_model

// ==== verif/tb.sv ====
// self-checking bench for the floating-point state block
`timescale 1ns/1ps
module tb;
  import fp_state_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        fp_wr_en = 1'b0;
  logic [4:0]  fp_wr_addr = 5'h00;
  logic [31:0] fp_wr_data = 32'h0000_0000;
  logic        fp_rd_en = 1'b0;
  logic [4:0]  fp_rd_addr_a = 5'h00;
  logic [4:0]  fp_rd_addr_b = 5'h00;
  logic [4:0]  fp_rd_addr_c = 5'h00;
  logic [31:0] rd_a, rd_b, rd_c, csr_rdata;
  logic        rd_valid, csr_rvalid, exc_valid, rm_rsv, illegal, rm_valid;
  logic        csr_req = 1'b0;
  csr_op_t     csr_op = read_whole_status;
  logic [31:0] src_int_reg = 32'h0000_0000;
  logic        fire = 1'b0;
  logic [4:0]  raise = 5'h00;
  logic [4:0]  exc_flags, flags;
  logic        rm_req = 1'b0;
  logic [2:0]  insn_round_select = 3'h0;
  logic [2:0]  eff_mode, round_field;
  logic [31:0] mirror [32] = '{default: 32'h0000_0000};
  int          mismatches = 0;
  int          num_checks = 0;

  always #12.5 ref_clk = ~ref_clk;

  fp_exec_model u_exec (.ref_clk(ref_clk), .rst(rst), .fire(fire),
    .raise(raise), .exc_valid(exc_valid), .exc_flags(exc_flags));

  fp_state_regfile u_dut (.ref_clk(ref_clk), .rst(rst),
    .fp_wr_en(fp_wr_en), .fp_wr_addr(fp_wr_addr), .fp_wr_data(fp_wr_data),
    .fp_rd_en(fp_rd_en), .fp_rd_addr_a(fp_rd_addr_a),
    .fp_rd_addr_b(fp_rd_addr_b), .fp_rd_addr_c(fp_rd_addr_c),
    .fp_rd_data_a_ff(rd_a), .fp_rd_data_b_ff(rd_b), .fp_rd_data_c_ff(rd_c),
    .fp_rd_valid_ff(rd_valid), .csr_req(csr_req), .csr_op(csr_op),
    .src_int_reg(src_int_reg), .csr_rdata_ff(csr_rdata),
    .csr_rvalid_ff(csr_rvalid), .exc_valid(exc_valid),
    .exc_flags(exc_flags), .rm_req(rm_req),
    .insn_round_select(insn_round_select), .eff_round_mode_ff(eff_mode),
    .round_reserved_ff(rm_rsv), .illegal_insn_ff(illegal),
    .rm_valid_ff(rm_valid), .round_field_ff(round_field), .flags_ff(flags));

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  // compare and count; case inequality so unknowns never match
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one control/status access; answer shows the state before it
  task automatic csr(input csr_op_t op, input logic [31:0] src,
                     input logic [31:0] exp);
    @(negedge ref_clk);
    fire = 1'b0;
    csr_req = 1'b1;
    csr_op = op;
    src_int_reg = src;
    @(negedge ref_clk);
    csr_req = 1'b0;
    src_int_reg = ~src;
    check("csr valid", {31'h0, csr_rvalid}, 32'h1);
    check(op.name(), csr_rdata, exp);
  endtask : csr

  task automatic fpw(input logic [4:0] a, input logic [31:0] d);
    @(negedge ref_clk);
    fp_wr_en = 1'b1;
    fp_wr_addr = a;
    fp_wr_data = d;
    mirror[a] = d;
    @(negedge ref_clk);
    fp_wr_en = 1'b0;
  endtask : fpw

  task automatic fpr(input logic [4:0] a, input logic [4:0] b,
                     input logic [4:0] c);
    @(negedge ref_clk);
    fp_rd_en = 1'b1;
    fp_rd_addr_a = a;
    fp_rd_addr_b = b;
    fp_rd_addr_c = c;
    @(negedge ref_clk);
    fp_rd_en = 1'b0;
    check("fp valid", {31'h0, rd_valid}, 32'h1);
    check("fp a", rd_a, mirror[a]);
    check("fp b", rd_b, mirror[b]);
    check("fp c", rd_c, mirror[c]);
  endtask : fpr

  // static code unless 7; anything above 4 after selection is reserved
  task automatic rmr(input logic [2:0] sel, input logic [2:0] field);
    logic [2:0] eff;
    logic       rsv;
    eff = (sel == 3'h7) ? field : sel;
    rsv = (eff > 3'h4);
    @(negedge ref_clk);
    rm_req = 1'b1;
    insn_round_select = sel;
    @(negedge ref_clk);
    rm_req = 1'b0;
    check("rm valid", {31'h0, rm_valid}, 32'h1);
    check("eff mode", {29'h0, eff_mode}, {29'h0, eff});
    check("reserved", {31'h0, rm_rsv}, {31'h0, rsv});
    check("illegal", {31'h0, illegal}, {31'h0, rsv});
  endtask : rmr

  // completion takes effect at the rising edge half a cycle after the model strobes
  task automatic exc(input logic [4:0] f);
    @(negedge ref_clk);
    fire = 1'b1;
    raise = f;
    @(negedge ref_clk);
    fire = 1'b0;
    @(negedge ref_clk);
  endtask : exc

  // watchdog at 2000 cycles, well beyond the roughly 72 cycles the tests need
  initial begin
    #(25 * 2000);
    mismatches++;
    summarize();
  end

  initial begin
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    check("round field", {29'h0, round_field}, 32'h0);
    check("flags", {27'h0, flags}, 32'h0);
    csr(read_whole_status, 32'h0, 32'h0);
    $display("test reset done");
    fpw(5'h00, 32'h3F80_0000);
    fpw(5'h1F, 32'hC0A0_0001);
    fpr(5'h00, 5'h1F, 5'h10);
    $display("test fp registers done");
    csr(swap_whole_status, 32'hFFFF_FF6A, 32'h0);
    csr(read_whole_status, 32'h0, 32'h0000_006A);
    check("round field", {29'h0, round_field}, 32'h3);
    check("flags", {27'h0, flags}, 32'h0A);
    csr(read_round_field, 32'h0, 32'h3);
    csr(swap_round_field, 32'hFFFF_FFFC, 32'h3);
    csr(read_flag_field, 32'h0, 32'h0A);
    csr(swap_flag_field, 32'hFFFF_FFF5, 32'h0A);
    csr(read_whole_status, 32'h0, 32'h0000_0095);
    $display("test status word done");
    for (int s = 0; s < 8; s++) rmr(s[2:0], 3'h4);
    for (int f = 5; f < 8; f++) begin
      csr(swap_round_field, 32'(f), 32'(f - 1));
      rmr(3'h7, f[2:0]);
    end
    $display("test rounding done");
    // clear with the upper bits kept as read, which were zero
    csr(swap_flag_field, 32'h0, 32'h15);
    exc(5'h01);
    check("flags", {27'h0, flags}, 32'h01);
    exc(5'h10);
    check("flags", {27'h0, flags}, 32'h11);
    csr(read_whole_status, 32'h0, 32'h0000_00F1);
    @(negedge ref_clk);
    fire = 1'b1;
    raise = 5'h04;
    csr(swap_flag_field, 32'h0000_0002, 32'h11);
    check("flags", {27'h0, flags}, 32'h06);
    $display("test flags done");
    // mid-run reset from a non-zero rounding field and flags
    @(negedge ref_clk);
    rst = 1'b1;
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    check("round field", {29'h0, round_field}, 32'h0);
    check("flags", {27'h0, flags}, 32'h0);
    csr(read_whole_status, 32'h0, 32'h0);
    $display("test mid reset done");
    summarize();
  end
endmodule : tb
